// *** pkg/fss_pkg.sv ***
// package: opcodes, field positions and flag positions for the flag/shift unit
package fss_pkg;
    localparam int          FSS_W         = 32;
    localparam int          FSS_OP_W      = 16;
    localparam int          FSS_REG_W     = 4;
    localparam int          FSS_AMT_W     = 5;
    // status register flag positions
    localparam int          FSS_COND_BIT  = 0;
    localparam int          FSS_SAT_BIT   = 1;
    localparam logic [31:0] FSS_SR_RESET  = 32'h0000_0000;
    localparam logic [31:0] FSS_PC_RESET  = 32'h0000_0000;
    localparam logic [31:0] FSS_PC_STEP   = 32'h0000_0002;
    // instruction field positions
    localparam int          FSS_N_LSB     = 8;
    localparam int          FSS_M_LSB     = 4;
    localparam int          FSS_MSB       = 31;
    // fixed shift amounts
    localparam int          FSS_SH2       = 2;
    localparam int          FSS_SH8       = 8;
    localparam int          FSS_SH16      = 16;
    // opcode patterns and masks
    localparam logic [15:0] FSS_MASK_FULL = 16'hFFFF;
    localparam logic [15:0] FSS_MASK_N    = 16'hF0FF;
    localparam logic [15:0] FSS_MASK_NM   = 16'hF00F;
    localparam logic [15:0] FSS_SET_SAT   = 16'h0058;
    localparam logic [15:0] FSS_SET_COND  = 16'h0018;
    localparam logic [15:0] FSS_DYN_ARITH = 16'h400C;
    localparam logic [15:0] FSS_DYN_LOGIC = 16'h400D;
    localparam logic [15:0] FSS_ASL1      = 16'h4020;
    localparam logic [15:0] FSS_ASR1      = 16'h4021;
    localparam logic [15:0] FSS_LSL1      = 16'h4000;
    localparam logic [15:0] FSS_LSR1      = 16'h4001;
    localparam logic [15:0] FSS_LSL2      = 16'h4008;
    localparam logic [15:0] FSS_LSL8      = 16'h4018;
    localparam logic [15:0] FSS_LSL16     = 16'h4028;
    localparam logic [15:0] FSS_LSR2      = 16'h4009;
    localparam logic [15:0] FSS_LSR8      = 16'h4019;
    localparam logic [15:0] FSS_LSR16     = 16'h4029;

    typedef enum logic [3:0] {
        FSS_OP_NONE, FSS_OP_SET_SAT, FSS_OP_SET_COND, FSS_OP_DYN_ARITH, FSS_OP_DYN_LOGIC,
        FSS_OP_ASL1, FSS_OP_ASR1, FSS_OP_LSL1, FSS_OP_LSR1, FSS_OP_LSL2, FSS_OP_LSL8,
        FSS_OP_LSL16, FSS_OP_LSR2, FSS_OP_LSR8, FSS_OP_LSR16
    } fss_op_e;
endpackage

// *** hw/fss_dyn_shifter.sv ***
// dynamic barrel shifter: direction and amount from the shift control register
`timescale 1ns/1ps
module fss_dyn_shifter
    import fss_pkg::*;
(
    // operands
    input  wire logic [FSS_W-1:0] target_in,
    input  wire logic [FSS_W-1:0] control_in,
    input  wire logic             arith_in,
    // result
    output logic      [FSS_W-1:0] result_out
);
    logic [FSS_AMT_W-1:0] amt;
    logic [FSS_AMT_W:0]   right_amt;
    logic                 fill;

    // amount selection and shift
    always_comb begin
        amt       = control_in[FSS_AMT_W-1:0];
        // two's complement magnitude; low bits of zero mean 32
        right_amt = (FSS_AMT_W+1)'(FSS_W) - {1'b0, amt}; // RULE_04
        fill      = arith_in & target_in[FSS_MSB]; // RULE_05 RULE_06
        if (!control_in[FSS_MSB]) begin
            result_out = target_in << amt; // RULE_03 RULE_05
        end else begin
            result_out = FSS_W'(({ {FSS_W{fill}}, target_in } >> right_amt)); // RULE_03 RULE_06
        end
    end
endmodule

// *** hw/fss_unit.sv ***
// flag-setting and shift execution unit with its status flags and pc
//
// Contract
// RULE_01 - set saturation flag, one cycle, condition kept
// RULE_02 - set condition flag, pc advances only
// RULE_03 - control sign selects left or right
// RULE_04 - amount from low five bits, right 1-32
// RULE_05 - arithmetic right fills sign, left fills zero
// RULE_06 - logical right fills zero, 32 gives zero
// RULE_07 - arith left one, msb to condition
// RULE_08 - arith right one, keep sign, lsb out
// RULE_09 - logical left one same as arith
// RULE_10 - logical right one, zero top, lsb out
// RULE_11 - fixed left 2/8/16, condition kept
// RULE_12 - fixed right 2/8/16, condition kept
// RULE_13 - decode dynamic shifts with n, m fields
// RULE_14 - dynamic shifts leave condition flag alone
`timescale 1ns/1ps
module fss_unit
    import fss_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 ce_in,
    // instruction from decoder
    input  wire logic                 instr_valid_in,
    input  wire logic [FSS_OP_W-1:0]  instr_in,
    // operands from register file
    input  wire logic [FSS_W-1:0]     target_register_in,
    input  wire logic [FSS_W-1:0]     shift_control_register_in,
    // write-back to register file
    output logic                      wr_en_out,
    output logic      [FSS_REG_W-1:0] wr_idx_out,
    output logic      [FSS_W-1:0]     wr_data_out,
    // read indices to register file
    output logic      [FSS_REG_W-1:0] target_idx_out,
    output logic      [FSS_REG_W-1:0] control_idx_out,
    // architectural state
    output logic      [FSS_W-1:0]     status_register_out,
    output logic      [FSS_W-1:0]     pc_out,
    output logic                      done_out
);
    fss_op_e              op;
    logic [FSS_REG_W-1:0] n_field;
    logic [FSS_REG_W-1:0] m_field;
    logic [FSS_W-1:0]     dyn_result;
    logic [FSS_W-1:0]     next_data;
    logic                 next_wr;
    logic                 next_cond;
    logic                 cond_wr;
    logic                 go;

    assign go      = ce_in & instr_valid_in;
    assign n_field = instr_in[FSS_N_LSB +: FSS_REG_W];
    assign m_field = instr_in[FSS_M_LSB +: FSS_REG_W];

    // instruction decode, exact codes first then field-masked patterns
    always_comb begin
        if (!instr_valid_in) begin
            op = FSS_OP_NONE;
        end else if ((instr_in & FSS_MASK_FULL) == FSS_SET_SAT) begin
            op = FSS_OP_SET_SAT;
        end else if ((instr_in & FSS_MASK_FULL) == FSS_SET_COND) begin
            op = FSS_OP_SET_COND;
        end else if ((instr_in & FSS_MASK_NM) == FSS_DYN_ARITH) begin
            op = FSS_OP_DYN_ARITH; // RULE_13
        end else if ((instr_in & FSS_MASK_NM) == FSS_DYN_LOGIC) begin
            op = FSS_OP_DYN_LOGIC; // RULE_13
        end else if ((instr_in & FSS_MASK_N) == FSS_ASL1) begin
            op = FSS_OP_ASL1;
        end else if ((instr_in & FSS_MASK_N) == FSS_ASR1) begin
            op = FSS_OP_ASR1;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSL1) begin
            op = FSS_OP_LSL1;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSR1) begin
            op = FSS_OP_LSR1;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSL2) begin
            op = FSS_OP_LSL2;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSL8) begin
            op = FSS_OP_LSL8;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSL16) begin
            op = FSS_OP_LSL16;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSR2) begin
            op = FSS_OP_LSR2;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSR8) begin
            op = FSS_OP_LSR8;
        end else if ((instr_in & FSS_MASK_N) == FSS_LSR16) begin
            op = FSS_OP_LSR16;
        end else begin
            op = FSS_OP_NONE;
        end
    end

    // dynamic shifter
    fss_dyn_shifter i_fss_dyn_shifter (
        .target_in  (target_register_in),
        .control_in (shift_control_register_in),
        .arith_in   (op == FSS_OP_DYN_ARITH),
        .result_out (dyn_result)
    );

    // result and condition flag selection
    always_comb begin
        next_data = target_register_in;
        next_wr   = 1'b1;
        next_cond = 1'b0;
        cond_wr   = 1'b0;
        case (op)
            FSS_OP_SET_COND: begin
                next_wr   = 1'b0;
                next_cond = 1'b1; // RULE_02
                cond_wr   = 1'b1;
            end
            FSS_OP_DYN_ARITH, FSS_OP_DYN_LOGIC: begin
                next_data = dyn_result; // RULE_14
            end
            FSS_OP_ASL1, FSS_OP_LSL1: begin
                next_data = target_register_in << 1; // RULE_07 RULE_09
                next_cond = target_register_in[FSS_MSB];
                cond_wr   = 1'b1;
            end
            FSS_OP_ASR1: begin
                next_data = {target_register_in[FSS_MSB], target_register_in[FSS_W-1:1]}; // RULE_08
                next_cond = target_register_in[0];
                cond_wr   = 1'b1;
            end
            FSS_OP_LSR1: begin
                next_data = {1'b0, target_register_in[FSS_W-1:1]}; // RULE_10
                next_cond = target_register_in[0];
                cond_wr   = 1'b1;
            end
            FSS_OP_LSL2:  next_data = target_register_in << FSS_SH2;  // RULE_11
            FSS_OP_LSL8:  next_data = target_register_in << FSS_SH8;  // RULE_11
            FSS_OP_LSL16: next_data = target_register_in << FSS_SH16; // RULE_11
            FSS_OP_LSR2:  next_data = target_register_in >> FSS_SH2;  // RULE_12
            FSS_OP_LSR8:  next_data = target_register_in >> FSS_SH8;  // RULE_12
            FSS_OP_LSR16: next_data = target_register_in >> FSS_SH16; // RULE_12
            default: begin
                next_wr = 1'b0;
            end
        endcase
    end

    // register read indices follow the instruction fields
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            target_idx_out  <= '0;
            control_idx_out <= '0;
        end else if (ce_in) begin
            target_idx_out  <= n_field;
            control_idx_out <= m_field; // RULE_13
        end
    end

    // write-back of the target register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_en_out   <= 1'b0;
            wr_idx_out  <= '0;
            wr_data_out <= '0;
            done_out    <= 1'b0;
        end else if (ce_in) begin
            wr_en_out   <= go & next_wr;
            wr_idx_out  <= n_field;
            wr_data_out <= next_data;
            done_out    <= go & (op != FSS_OP_NONE);
        end
    end

    // status register flags
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_register_out <= FSS_SR_RESET;
        end else if (go) begin
            if (op == FSS_OP_SET_SAT) begin
                status_register_out[FSS_SAT_BIT] <= 1'b1; // RULE_01
            end
            if (cond_wr) begin
                status_register_out[FSS_COND_BIT] <= next_cond; // RULE_02 RULE_07 RULE_08 RULE_10
            end
        end
    end

    // program counter advances one instruction per executed op
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_out <= FSS_PC_RESET;
        end else if (go && op != FSS_OP_NONE) begin
            pc_out <= pc_out + FSS_PC_STEP; // RULE_02
        end
    end

    // checks
    property p_set_sat;
        @(posedge clk_in) disable iff (rst_in)
        (go && op == FSS_OP_SET_SAT) |=> status_register_out[FSS_SAT_BIT]
            && status_register_out[FSS_COND_BIT] == $past(status_register_out[FSS_COND_BIT]);
    endproperty
    a_set_sat: assert property (p_set_sat) else $error("saturation flag not set"); // RULE_01

    property p_set_cond;
        @(posedge clk_in) disable iff (rst_in)
        (go && op == FSS_OP_SET_COND) |=> status_register_out[FSS_COND_BIT] && !wr_en_out
            && pc_out == $past(pc_out) + FSS_PC_STEP;
    endproperty
    a_set_cond: assert property (p_set_cond) else $error("condition flag set failed"); // RULE_02

    property p_dyn_left;
        @(posedge clk_in) disable iff (rst_in)
        (go && (op == FSS_OP_DYN_ARITH || op == FSS_OP_DYN_LOGIC) && !shift_control_register_in[FSS_MSB])
        |=> wr_data_out == ($past(target_register_in) << $past(shift_control_register_in[4:0]));
    endproperty
    a_dyn_left: assert property (p_dyn_left) else $error("dynamic left shift wrong"); // RULE_03 RULE_04

    property p_dyn_arith_right;
        @(posedge clk_in) disable iff (rst_in)
        (go && op == FSS_OP_DYN_ARITH && shift_control_register_in[FSS_MSB]
            && shift_control_register_in[4:0] == 5'h00)
        |=> wr_data_out == {FSS_W{$past(target_register_in[FSS_MSB])}};
    endproperty
    a_dyn_arith_right: assert property (p_dyn_arith_right) else $error("arith right 32 wrong"); // RULE_05

    property p_dyn_logic_right;
        @(posedge clk_in) disable iff (rst_in)
        (go && op == FSS_OP_DYN_LOGIC && shift_control_register_in[FSS_MSB])
        |=> wr_data_out == ($past(target_register_in) >> (6'h20 - {1'b0, $past(shift_control_register_in[4:0])}));
    endproperty
    a_dyn_logic_right: assert property (p_dyn_logic_right) else $error("logic right wrong"); // RULE_06 RULE_04

    sequence s_left_one;
        go && (op == FSS_OP_ASL1 || op == FSS_OP_LSL1);
    endsequence
    property p_left_one;
        @(posedge clk_in) disable iff (rst_in)
        s_left_one |=> wr_en_out && wr_data_out == {$past(target_register_in[FSS_W-2:0]), 1'b0}
            && status_register_out[FSS_COND_BIT] == $past(target_register_in[FSS_MSB]);
    endproperty
    a_left_one: assert property (p_left_one) else $error("left one shift wrong"); // RULE_07 RULE_09

    property p_right_one;
        @(posedge clk_in) disable iff (rst_in)
        (go && (op == FSS_OP_ASR1 || op == FSS_OP_LSR1)) |=>
            wr_data_out[FSS_W-2:0] == $past(target_register_in[FSS_W-1:1])
            && wr_data_out[FSS_MSB] == ($past(op == FSS_OP_ASR1) & $past(target_register_in[FSS_MSB]))
            && status_register_out[FSS_COND_BIT] == $past(target_register_in[0]);
    endproperty
    a_right_one: assert property (p_right_one) else $error("right one shift wrong"); // RULE_08 RULE_10

    property p_fixed_keep_cond;
        @(posedge clk_in) disable iff (rst_in)
        (go && (op == FSS_OP_LSL2 || op == FSS_OP_LSL8 || op == FSS_OP_LSL16 || op == FSS_OP_LSR2
            || op == FSS_OP_LSR8 || op == FSS_OP_LSR16 || op == FSS_OP_DYN_ARITH || op == FSS_OP_DYN_LOGIC))
        |=> $stable(status_register_out) && wr_en_out;
    endproperty
    a_fixed_keep_cond: assert property (p_fixed_keep_cond) else $error("flag changed"); // RULE_11 RULE_12 RULE_14

    property p_fixed_value;
        @(posedge clk_in) disable iff (rst_in)
        (go && op == FSS_OP_LSR8) |=> wr_data_out == {8'h00, $past(target_register_in[FSS_W-1:8])}
            && wr_idx_out == $past(n_field);
    endproperty
    a_fixed_value: assert property (p_fixed_value) else $error("fixed right shift wrong"); // RULE_12 RULE_13
endmodule

// *** sim/fss_unit_test.sv ***
// self-checking bench for the flag-setting and shift unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module fss_unit_test
    import fss_pkg::*;
;
    // clock, reset and stimulus
    logic                 clk_in                    = 1'b0;
    logic                 rst_in                    = 1'b1;
    logic                 ce_in                     = 1'b1;
    logic                 instr_valid_in            = 1'b0;
    logic [FSS_OP_W-1:0]  instr_in                  = 16'h0000;
    logic [FSS_W-1:0]     target_register_in        = 32'h0000_0000;
    logic [FSS_W-1:0]     shift_control_register_in = 32'h0000_0000;
    // observed outputs
    logic                 wr_en_out;
    logic [FSS_REG_W-1:0] wr_idx_out;
    logic [FSS_W-1:0]     wr_data_out;
    logic [FSS_REG_W-1:0] target_idx_out;
    logic [FSS_REG_W-1:0] control_idx_out;
    logic [FSS_W-1:0]     status_register_out;
    logic [FSS_W-1:0]     pc_out;
    logic                 done_out;
    // bench bookkeeping
    int                   err_count       = 0;
    int                   samples_checked = 0;
    logic [FSS_W-1:0]     exp_sr;
    logic [FSS_W-1:0]     exp_pc;

    always #4 clk_in = ~clk_in;

    fss_unit i_fss_unit (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .target_register_in(target_register_in),
        .shift_control_register_in(shift_control_register_in), .wr_en_out(wr_en_out), .wr_idx_out(wr_idx_out),
        .wr_data_out(wr_data_out), .target_idx_out(target_idx_out), .control_idx_out(control_idx_out),
        .status_register_out(status_register_out), .pc_out(pc_out), .done_out(done_out));

    // verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // present one instruction at the falling edge, settle after the taking edge
    task automatic issue(input logic [15:0] op, input logic [31:0] tgt, input logic [31:0] ctl);
        @(negedge clk_in);
        instr_valid_in = 1'b1;
        instr_in = op;
        target_register_in = tgt;
        shift_control_register_in = ctl;
        @(posedge clk_in);
        #1;
    endtask

    // execute a recognised instruction; cmode = {changes condition, new value}
    task automatic do_op(input logic [15:0] op, input logic [31:0] tgt, input logic [31:0] ctl,
                         input logic wr, input logic [31:0] data, input logic [1:0] cmode);
        issue(op, tgt, ctl);
        exp_pc = exp_pc + FSS_PC_STEP;
        if (cmode[1]) begin
            exp_sr[FSS_COND_BIT] = cmode[0];
        end
        `CHK("done", 1'b1, done_out)
        `CHK("write enable", wr, wr_en_out)
        if (wr) begin
            `CHK("write index", op[11:8], wr_idx_out)
            `CHK("write data", data, wr_data_out)
        end
        `CHK("status", exp_sr, status_register_out)
        `CHK("pc", exp_pc, pc_out)
    endtask

    // reset: status, pc, write enable and done cleared
    task automatic test_reset();
        @(negedge clk_in);
        rst_in = 1'b1;
        instr_valid_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
        `CHK("status after reset", FSS_SR_RESET, status_register_out)
        `CHK("pc after reset", FSS_PC_RESET, pc_out)
        `CHK("write enable after reset", 1'b0, wr_en_out)
        `CHK("done after reset", 1'b0, done_out)
        @(negedge clk_in);
        rst_in = 1'b0;
        exp_sr = FSS_SR_RESET;
        exp_pc = FSS_PC_RESET;
        $display("test reset finished");
    endtask

    // flag setters, with condition set and clear around them
    task automatic test_flags();
        do_op(16'h4021, 32'h0000_0001, 32'h0, 1'b1, 32'h0000_0000, 2'b11);
        exp_sr[FSS_SAT_BIT] = 1'b1;
        do_op(FSS_SET_SAT, 32'h0000_0000, 32'h0, 1'b0, 32'h0, 2'b00);
        do_op(16'h4000, 32'h0000_0001, 32'h0, 1'b1, 32'h0000_0002, 2'b10);
        do_op(FSS_SET_COND, 32'h0000_0000, 32'h0, 1'b0, 32'h0, 2'b11);
        $display("test flags finished");
    endtask

    // one-bit shifts back to back, shifted-out bit into condition
    task automatic test_one_bit();
        do_op(16'h4320, 32'h8000_0001, 32'h0, 1'b1, 32'h0000_0002, 2'b11);
        do_op(16'h4420, 32'h7FFF_FFFF, 32'h0, 1'b1, 32'hFFFF_FFFE, 2'b10);
        do_op(16'h4521, 32'h8000_0001, 32'h0, 1'b1, 32'hC000_0000, 2'b11);
        do_op(16'h4621, 32'h7FFF_FFFE, 32'h0, 1'b1, 32'h3FFF_FFFF, 2'b10);
        do_op(16'h4700, 32'h8000_0001, 32'h0, 1'b1, 32'h0000_0002, 2'b11);
        do_op(16'h4801, 32'h8000_0001, 32'h0, 1'b1, 32'h4000_0000, 2'b11);
        do_op(16'h4901, 32'hFFFF_FFFE, 32'h0, 1'b1, 32'h7FFF_FFFF, 2'b10);
        $display("test one bit finished");
    endtask

    // fixed shifts by 2, 8 and 16 leave condition as it stands
    task automatic test_fixed();
        logic [15:0] ops [6] = '{16'h4A08, 16'h4B18, 16'h4C28, 16'h4D09, 16'h4E19, 16'h4F29};
        logic [31:0] res [6] = '{32'h48D1_59E0, 32'h3456_7800, 32'h5678_0000,
                                 32'h048D_159E, 32'h0012_3456, 32'h0000_1234};
        for (int i = 0; i < 6; i++) begin
            do_op(ops[i], 32'h1234_5678, 32'h0, 1'b1, res[i], 2'b00);
        end
        do_op(FSS_SET_COND, 32'h0, 32'h0, 1'b0, 32'h0, 2'b11);
        do_op(16'h4109, 32'hFFFF_FFFF, 32'h0, 1'b1, 32'h3FFF_FFFF, 2'b00);
        do_op(16'h4128, 32'hFFFF_FFFF, 32'h0, 1'b1, 32'hFFFF_0000, 2'b00);
        $display("test fixed finished");
    endtask

    // dynamic shifts: direction, amount, fill and unchanged condition
    task automatic test_dyn();
        do_op(16'h421C, 32'h8018_0000, 32'hFFFF_FFEC, 1'b1, 32'hFFFF_F801, 2'b00);
        `CHK("target index", 4'h2, target_idx_out)
        `CHK("control index", 4'h1, control_idx_out)
        do_op(16'h421D, 32'h8018_0000, 32'hFFFF_FFEC, 1'b1, 32'h0000_0801, 2'b00);
        do_op(16'h443C, 32'hFFFF_F801, 32'h0000_0014, 1'b1, 32'h8010_0000, 2'b00);
        do_op(16'h443D, 32'hFFFF_F801, 32'h0000_0014, 1'b1, 32'h8010_0000, 2'b00);
        do_op(16'h4F0C, 32'h8000_0000, 32'h8000_0000, 1'b1, 32'hFFFF_FFFF, 2'b00);
        do_op(16'h4F0D, 32'hFFFF_FFFF, 32'hFFFF_FFE0, 1'b1, 32'h0000_0000, 2'b00);
        do_op(16'h45EC, 32'h1234_5678, 32'h0000_0000, 1'b1, 32'h1234_5678, 2'b00);
        do_op(16'h45ED, 32'h0000_0003, 32'h0000_00FF, 1'b1, 32'h8000_0000, 2'b00);
        do_op(16'h467C, 32'h8000_0002, 32'hFFFF_FFFF, 1'b1, 32'hC000_0001, 2'b00);
        do_op(16'h4000, 32'h0000_0000, 32'h0, 1'b1, 32'h0000_0000, 2'b10);
        do_op(16'h487D, 32'h8000_0002, 32'hFFFF_FFFF, 1'b1, 32'h4000_0001, 2'b00);
        $display("test dynamic finished");
    endtask

    // unknown code and clock enable low change nothing
    task automatic test_refuse();
        issue(16'h4002, 32'h1234_5678, 32'h0);
        `CHK("done on unknown", 1'b0, done_out)
        `CHK("write on unknown", 1'b0, wr_en_out)
        `CHK("pc on unknown", exp_pc, pc_out)
        `CHK("status on unknown", exp_sr, status_register_out)
        @(negedge clk_in);
        ce_in = 1'b0;
        issue(FSS_SET_COND, 32'h0, 32'h0);
        `CHK("status frozen", exp_sr, status_register_out)
        `CHK("pc frozen", exp_pc, pc_out)
        @(negedge clk_in);
        ce_in = 1'b1;
        instr_valid_in = 1'b0;
        $display("test refuse finished");
    endtask

    // hang guard
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        test_reset();
        test_flags();
        test_one_bit();
        test_fixed();
        test_dyn();
        test_refuse();
        test_flags();
        test_reset();
        test_one_bit();
        print_verdict();
    end
endmodule
